/* File: rtl/ccx_pkg.sv */
package ccx_pkg;
    // Operation selector codes presented on op_sel
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_WATCHDOG_CLEAR = 3'h1;
    localparam logic [2:0] OP_INDIRECT_CALL = 3'h2;
    localparam logic [2:0] OP_COMPLEMENT = 3'h3;
    localparam logic [2:0] OP_FILE_CLEAR = 3'h4;
    localparam logic [2:0] OP_DECREMENT = 3'h5;
    localparam logic [2:0] OP_ACCUM_CLEAR = 3'h6;
    // Destination bit meaning
    localparam logic DEST_ACCUM = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    // Field widths of the program counter
    localparam int PC_W = 15;
    localparam int PC_LOW_W = 8;
    localparam int LATCH_HIGH_W = 7;
    // Reset and constant values
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [14:0] PC_ONE = 15'h0001;
    // Call takes two instruction cycles: execute then flush
    localparam int CALL_CYCLES = 2;
    // Sequencer states, Gray along the call path
    typedef enum logic [1:0] {
        CCX_IDLE = 2'b00,
        CCX_FLUSH = 2'b01
    } ccx_state_type;
endpackage

/* File: rtl/ccx_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - watchdog clear pulses watchdog_clear_ff, sets flags
// - indirect call pushes PC plus one
// - indirect call loads PC from accumulator, latch
// - indirect call two cycles, flags untouched
// - complement inverts file, updates zero flag
// - destination bit selects accumulator or file
// - decrement subtracts one, updates zero, no skip
// - file clear writes zero, sets zero flag
// - accumulator clear writes zero, sets zero
module ccx_exec
    import ccx_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [2:0] op_sel,
    input wire logic dest_bit,
    input wire logic [7:0] file_rdata,
    input wire logic [7:0] accum_in,
    input wire logic [6:0] program_counter_high_latch,
    input wire logic [14:0] pc_in,
    output logic op_busy,
    output logic [7:0] accum_ff,
    output logic [7:0] file_wdata_ff,
    output logic file_we_ff,
    output logic zero_ff,
    output logic zero_we_ff,
    output logic watchdog_clear_ff,
    output logic watchdog_expiry_n_ff,
    output logic sleep_entered_n_ff,
    output logic [14:0] stack_top_ff,
    output logic stack_push_ff,
    output logic [14:0] pc_ff,
    output logic pc_load_ff
);
    // Zero detection for the complement and decrement results
    function automatic logic is_zero(input logic [7:0] v);
        return v == ZERO_BYTE;
    endfunction

    ccx_state_type state_ff; // Call sequencer state
    ccx_state_type nxt_state;
    logic take; // Accepted operation this cycle
    logic [7:0] result; // ALU result for file ops

    assign take = op_valid && (state_ff == CCX_IDLE);
    // Busy during the second call cycle refuses new ops
    assign op_busy = (state_ff == CCX_FLUSH);

    // ALU result selection
    always_comb begin
        case (op_sel)
            OP_COMPLEMENT: result = ~file_rdata;
            OP_DECREMENT: result = file_rdata - ONE_BYTE;
            default: result = ZERO_BYTE;
        endcase
    end

    // Next state of the call sequencer
    always_comb begin
        case (state_ff)
            CCX_IDLE: nxt_state = (take && op_sel == OP_INDIRECT_CALL) ? CCX_FLUSH : CCX_IDLE;
            CCX_FLUSH: nxt_state = CCX_IDLE;
            default: nxt_state = CCX_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= CCX_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Accumulator and file write path
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            accum_ff <= ZERO_BYTE;
            file_wdata_ff <= ZERO_BYTE;
            file_we_ff <= 1'b0;
        end else begin
            file_we_ff <= 1'b0;
            if (take) begin
                case (op_sel)
                    OP_COMPLEMENT, OP_DECREMENT: begin
                        if (dest_bit == DEST_ACCUM) begin
                            accum_ff <= result;
                        end else begin
                            file_wdata_ff <= result;
                            file_we_ff <= 1'b1;
                        end
                    end
                    OP_FILE_CLEAR: begin
                        file_wdata_ff <= ZERO_BYTE;
                        file_we_ff <= 1'b1;
                    end
                    OP_ACCUM_CLEAR: accum_ff <= ZERO_BYTE;
                    default: accum_ff <= accum_in;
                endcase
            end else begin
                // Track the core accumulator when no op is taken
                accum_ff <= accum_in;
            end
        end
    end

    // Zero flag update
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            zero_ff <= 1'b0;
            zero_we_ff <= 1'b0;
        end else begin
            zero_we_ff <= 1'b0;
            if (take) begin
                case (op_sel)
                    OP_COMPLEMENT, OP_DECREMENT: begin
                        zero_ff <= is_zero(result);
                        zero_we_ff <= 1'b1;
                    end
                    OP_FILE_CLEAR, OP_ACCUM_CLEAR: begin
                        zero_ff <= 1'b1;
                        zero_we_ff <= 1'b1;
                    end
                    default: zero_we_ff <= 1'b0;
                endcase
            end
        end
    end

    // Watchdog clear and power status bits
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            watchdog_clear_ff <= 1'b0;
            watchdog_expiry_n_ff <= 1'b1;
            sleep_entered_n_ff <= 1'b1;
        end else begin
            watchdog_clear_ff <= take && (op_sel == OP_WATCHDOG_CLEAR);
            if (take && op_sel == OP_WATCHDOG_CLEAR) begin
                watchdog_expiry_n_ff <= 1'b1;
                sleep_entered_n_ff <= 1'b1;
            end
        end
    end

    // Call: push and program counter load
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stack_top_ff <= PC_RESET;
            stack_push_ff <= 1'b0;
            pc_ff <= PC_RESET;
            pc_load_ff <= 1'b0;
        end else begin
            stack_push_ff <= 1'b0;
            pc_load_ff <= 1'b0;
            if (take && op_sel == OP_INDIRECT_CALL) begin
                stack_top_ff <= pc_in + PC_ONE;
                stack_push_ff <= 1'b1;
                pc_ff <= {program_counter_high_latch, accum_in};
                pc_load_ff <= 1'b1;
            end
        end
    end

    // Assertions
    a_call_push_pc: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_INDIRECT_CALL) |=> (stack_push_ff && stack_top_ff == $past(pc_in) + PC_ONE))
        else $error("call did not push pc plus one");
    a_call_target: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_INDIRECT_CALL)
        |=> (pc_load_ff && pc_ff == {$past(program_counter_high_latch), $past(accum_in)}))
        else $error("call target wrong");
    a_call_two_cycles: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_INDIRECT_CALL) |=> (op_busy && !zero_we_ff) ##1 !op_busy)
        else $error("call not two cycles or touched flags");
    a_wdt_clear_bits: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_WATCHDOG_CLEAR) |=> (watchdog_clear_ff && watchdog_expiry_n_ff && sleep_entered_n_ff))
        else $error("watchdog clear incomplete");
    a_comp_result: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_COMPLEMENT && dest_bit == DEST_ACCUM) |=> (accum_ff == ~$past(file_rdata)))
        else $error("complement result wrong");
    a_dest_file: assert property (@(posedge mclk) disable iff (rst)
        (take && (op_sel == OP_COMPLEMENT || op_sel == OP_DECREMENT)) |=> (file_we_ff == $past(dest_bit)))
        else $error("destination routing wrong");
    a_dec_result: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_DECREMENT && dest_bit == DEST_FILE) |=> (file_wdata_ff == $past(file_rdata) - ONE_BYTE))
        else $error("decrement result wrong");
    a_fclr_zero: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_FILE_CLEAR) |=> (file_we_ff && file_wdata_ff == ZERO_BYTE && zero_ff && zero_we_ff))
        else $error("file clear wrong");
    a_wclr_zero: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_ACCUM_CLEAR) |=> (accum_ff == ZERO_BYTE && zero_ff && !file_we_ff))
        else $error("accumulator clear wrong");
    a_zero_flag: assert property (@(posedge mclk) disable iff (rst)
        (take && (op_sel == OP_COMPLEMENT || op_sel == OP_DECREMENT)) |=> (zero_we_ff && zero_ff == is_zero($past(result))))
        else $error("zero flag mismatch");
    a_comp_file: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_COMPLEMENT && dest_bit == DEST_FILE) |=> (file_wdata_ff == ~$past(file_rdata)))
        else $error("complement file result wrong");
    a_dec_accum: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_DECREMENT && dest_bit == DEST_ACCUM) |=> (accum_ff == $past(file_rdata) - ONE_BYTE))
        else $error("decrement accumulator result wrong");
    a_call_flags_kept: assert property (@(posedge mclk) disable iff (rst)
        (take && op_sel == OP_INDIRECT_CALL)
        |=> ($stable(zero_ff) && $stable(watchdog_expiry_n_ff) && $stable(sleep_entered_n_ff)))
        else $error("call changed a status flag");
    a_busy_refused: assert property (@(posedge mclk) disable iff (rst)
        op_busy |=> (!stack_push_ff && !pc_load_ff && !file_we_ff && !zero_we_ff && !watchdog_clear_ff))
        else $error("request taken while busy");
endmodule
`default_nettype wire

/* File: tb/tb_ccx_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ccx_exec
    import ccx_pkg::*;
;
    logic mclk = 1'b0; // Core clock, 5 ns period
    logic rst = 1'b1; // Asynchronous reset, active high
    logic op_valid = 1'b0, dest_bit = 1'b0;
    logic [2:0] op_sel = OP_NONE;
    logic [7:0] file_rdata = 8'h00, accum_in = 8'h00;
    logic [6:0] program_counter_high_latch = 7'h00;
    logic [14:0] pc_in = 15'h0000;
    logic op_busy, file_we_ff, zero_ff, zero_we_ff, watchdog_clear_ff;
    logic watchdog_expiry_n_ff, sleep_entered_n_ff, stack_push_ff, pc_load_ff;
    logic [7:0] accum_ff, file_wdata_ff;
    logic [14:0] stack_top_ff, pc_ff;
    int n_mismatch = 0; // Mismatches seen
    int tests_run = 0; // Comparisons made
    ccx_exec i_ccx_exec (.mclk(mclk), .rst(rst), .op_valid(op_valid), .op_sel(op_sel), .dest_bit(dest_bit),
        .file_rdata(file_rdata), .accum_in(accum_in), .program_counter_high_latch(program_counter_high_latch),
        .pc_in(pc_in), .op_busy(op_busy), .accum_ff(accum_ff), .file_wdata_ff(file_wdata_ff),
        .file_we_ff(file_we_ff), .zero_ff(zero_ff), .zero_we_ff(zero_we_ff), .watchdog_clear_ff(watchdog_clear_ff),
        .watchdog_expiry_n_ff(watchdog_expiry_n_ff), .sleep_entered_n_ff(sleep_entered_n_ff),
        .stack_top_ff(stack_top_ff), .stack_push_ff(stack_push_ff), .pc_ff(pc_ff), .pc_load_ff(pc_load_ff));
    // Clock generator
    always #2.5 mclk = ~mclk;
    // Compare one value and count it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Present one request, let it be taken, settle just after the answer edge
    task automatic issue(input logic [2:0] op, input logic d, input logic [7:0] f, input logic [7:0] a, input logic hold);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_sel <= op;
        dest_bit <= d;
        file_rdata <= f;
        accum_in <= a;
        @(posedge mclk);
        if (!hold) begin
            op_valid <= 1'b0;
        end
        #1;
    endtask
    // Watchdog clear pulses and sets both status bits
    task automatic t_wdog();
        issue(OP_WATCHDOG_CLEAR, 1'b0, 8'h00, 8'h00, 1'b0);
        chk(16'(watchdog_clear_ff), 16'h0001);
        chk(16'({watchdog_expiry_n_ff, sleep_entered_n_ff, zero_we_ff}), 16'h0006);
    endtask
    // Call with wrapping return address, then a held request refused while busy
    task automatic t_call();
        @(posedge mclk);
        program_counter_high_latch <= 7'h5a;
        pc_in <= 15'h7fff;
        issue(OP_INDIRECT_CALL, 1'b0, 8'h00, 8'ha5, 1'b1);
        chk({stack_push_ff, stack_top_ff}, {1'b1, 15'h0000});
        chk({pc_load_ff, pc_ff}, {1'b1, 7'h5a, 8'ha5});
        chk(16'({op_busy, zero_we_ff}), 16'h0002);
        @(posedge mclk);
        op_valid <= 1'b0;
        #1;
        chk(16'({stack_push_ff, pc_load_ff, op_busy, zero_we_ff}), 16'h0000);
    endtask
    // Complement to accumulator and to file, zero and non-zero results
    task automatic t_comp();
        issue(OP_COMPLEMENT, DEST_ACCUM, 8'hff, 8'h12, 1'b0);
        chk(16'({accum_ff, file_we_ff, zero_we_ff, zero_ff}), 16'({8'h00, 3'b011}));
        issue(OP_COMPLEMENT, DEST_FILE, 8'h3c, 8'h12, 1'b0);
        chk(16'({file_wdata_ff, file_we_ff, zero_we_ff, zero_ff}), 16'({8'hc3, 3'b110}));
    endtask
    // Decrement to zero into file, and wrap below zero into accumulator
    task automatic t_dec();
        issue(OP_DECREMENT, DEST_FILE, 8'h01, 8'h34, 1'b0);
        chk(16'({file_wdata_ff, file_we_ff, zero_we_ff, zero_ff, pc_load_ff}), 16'({8'h00, 4'b1110}));
        issue(OP_DECREMENT, DEST_ACCUM, 8'h00, 8'h34, 1'b0);
        chk(16'({accum_ff, file_we_ff, zero_we_ff, zero_ff, op_busy}), 16'({8'hff, 4'b0100}));
    endtask
    // Both clears force the zero flag; each starts from a non-zero value and a clear flag
    task automatic t_clear();
        issue(OP_ACCUM_CLEAR, 1'b0, 8'h55, 8'h77, 1'b0);
        chk(16'({accum_ff, file_we_ff, zero_we_ff, zero_ff}), 16'({8'h00, 3'b011}));
        issue(OP_COMPLEMENT, DEST_FILE, 8'h0f, 8'h77, 1'b0);
        chk(16'({file_wdata_ff, file_we_ff, zero_we_ff, zero_ff}), 16'({8'hf0, 3'b110}));
        issue(OP_FILE_CLEAR, 1'b0, 8'h55, 8'h66, 1'b0);
        chk(16'({file_wdata_ff, file_we_ff, zero_we_ff, zero_ff}), 16'({8'h00, 3'b111}));
    endtask
    // Verdict and end of run
    task automatic report_and_stop();
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge mclk);
        #1;
        chk(16'({op_busy, file_we_ff, zero_we_ff, watchdog_clear_ff}), 16'h0000);
        chk(16'({stack_push_ff, pc_load_ff, watchdog_expiry_n_ff, sleep_entered_n_ff}), 16'h0003);
        // Release on the sixth edge, so the first request lands two edges later
        @(posedge mclk);
        rst <= 1'b0;
        t_wdog();
        t_call();
        t_comp();
        t_dec();
        t_clear();
        report_and_stop();
    end
    // Hang guard, far beyond the few dozen cycles the tests need
    initial begin
        #2000;
        n_mismatch++;
        report_and_stop();
    end
endmodule
`default_nettype wire
